// file: src/nst_exec.sv
// Execution of nibble swap and table read instructions
`timescale 1ns/1ps
module nst_exec
   import nst_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [1:0] q_phase,
   input wire logic instr_valid,
   input wire nst_instr_t instr,
   input wire logic [7:0] file_rdata,
   input wire logic [15:0] pmem_rdata,
   output nst_wr_t wr,
   output logic [15:0] table_pointer,
   output logic [15:0] table_latch,
   output logic busy,
   output logic status_we
);
   nst_state_t state, next_state;
   nst_wr_t next_wr;
   logic [15:0] next_pointer, next_latch;
   logic next_busy;
   logic next_status_we;
   logic incr_pend, next_incr_pend;
   logic [1:0] cyc, next_cyc;
   logic q4;

   assign q4 = (q_phase == Q_LAST);

   // Next-state and datapath for both instructions
   always_comb begin
      next_state = state;
      next_wr = '0;
      next_pointer = table_pointer;
      next_latch = table_latch;
      next_busy = busy;
      next_incr_pend = incr_pend;
      next_cyc = cyc;
      next_status_we = 1'b0;
      case (state)
         ST_IDLE: begin
            if (instr_valid && q4 && instr.swap) begin
               next_wr.data = {file_rdata[NIB_LO +: 4], file_rdata[NIB_HI +: 4]};
               next_wr.addr = instr.faddr;
               next_wr.file_we = instr.dest_file;
               next_wr.work_reg_we = !instr.dest_file;
            end else if (instr_valid && q4 && instr.tread) begin
               next_wr.data = instr.byte_high ? table_latch[15:8] : table_latch[7:0];
               next_wr.addr = instr.faddr;
               next_wr.file_we = 1'b1;
               next_incr_pend = instr.incr;
               next_cyc = (instr.faddr == PC_LOW_ADDR) ? 2'(TR_CYCLES_PC_LOW - 1) : 2'(TR_CYCLES - 1);
               next_busy = 1'b1;
               next_state = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (q4) begin
               next_latch = pmem_rdata;
               if (incr_pend) begin
                  next_pointer = table_pointer + 16'h0001;
               end
               next_cyc = cyc - 2'h1;
               if (cyc == 2'h1) begin
                  next_busy = 1'b0;
                  next_state = ST_IDLE;
               end else begin
                  next_state = ST_EXTRA;
               end
            end
         end
         ST_EXTRA: begin
            if (q4) begin
               next_busy = 1'b0;
               next_cyc = 2'h0;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         wr <= '0;
         table_pointer <= PTR_RESET;
         table_latch <= LATCH_RESET;
         busy <= 1'b0;
         incr_pend <= 1'b0;
         cyc <= 2'h0;
         status_we <= 1'b0;
      end else begin
         state <= next_state;
         wr <= next_wr;
         table_pointer <= next_pointer;
         table_latch <= next_latch;
         busy <= next_busy;
         incr_pend <= next_incr_pend;
         cyc <= next_cyc;
         status_we <= next_status_we;
      end
   end

   // Swap result written at Q4 with nibbles exchanged
   a_swap_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (instr_valid && q4 && instr.swap && state == ST_IDLE) |=>
      (wr.data == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}))
      else $error("swap result wrong");

   // Swap destination follows the d bit
   a_swap_dest: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (instr_valid && q4 && instr.swap && state == ST_IDLE) |=>
      (wr.file_we == $past(instr.dest_file) && wr.work_reg_we != $past(instr.dest_file)))
      else $error("swap destination wrong");

   // Swap carries the operand address on both destinations
   a_swap_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (instr_valid && q4 && instr.swap && state == ST_IDLE) |=>
      (wr.addr == $past(instr.faddr)))
      else $error("swap address wrong");

   // Never a file write and a working register write together
   a_wr_onehot: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !(wr.file_we && wr.work_reg_we))
      else $error("both write strobes high");

   // Write strobes last one clock only
   a_wr_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (wr.file_we || wr.work_reg_we) |=> !(wr.file_we || wr.work_reg_we))
      else $error("write strobe longer than one clock");

   // No write unless an instruction was taken at Q4
   a_wr_cause: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !(instr_valid && q4 && state == ST_IDLE && (instr.swap || instr.tread)) |=>
      !(wr.file_we || wr.work_reg_we))
      else $error("write without a taken instruction");

   // Moved byte follows the byte-select bit
   a_tread_byte: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (instr_valid && q4 && instr.tread && state == ST_IDLE) |=>
      (wr.file_we && wr.data == ($past(instr.byte_high) ? $past(table_latch[15:8]) : $past(table_latch[7:0]))))
      else $error("table byte select wrong");

   // Table read writes the file register named by its operand
   a_tread_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (instr_valid && q4 && instr.tread && state == ST_IDLE) |=>
      (wr.addr == $past(instr.faddr) && !wr.work_reg_we))
      else $error("table read address wrong");

   // Latch still holds the old word while its byte moves out
   a_tread_before: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (instr_valid && q4 && instr.tread && state == ST_IDLE) |=> $stable(table_latch))
      else $error("latch reloaded before move");

   // Fetch Q4 comes one instruction cycle after the take
   a_fetch_time: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (instr_valid && q4 && instr.tread && state == ST_IDLE) |=>
      (state == ST_FETCH && !q4) [*3] ##1 (state == ST_FETCH && q4))
      else $error("fetch not one instruction cycle after take");

   // Latch takes the program word on the fetch Q4
   a_latch_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (state == ST_FETCH && q4) |=> (table_latch == $past(pmem_rdata)))
      else $error("latch not loaded");

   // Latch changes nowhere else
   a_latch_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !(state == ST_FETCH && q4) |=> $stable(table_latch))
      else $error("latch changed outside fetch");

   // Pointer advances by the increment bit on the load
   a_ptr_incr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (state == ST_FETCH && q4) |=>
      (table_pointer == $past(table_pointer) + ($past(incr_pend) ? 16'h0001 : 16'h0000)))
      else $error("pointer update wrong");

   // Pointer holds outside the fetch cycle
   a_ptr_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (state != ST_FETCH) |=> $stable(table_pointer))
      else $error("pointer moved outside load");

   // Cycle budget picked from the destination at the take
   a_cyc_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (instr_valid && q4 && instr.tread && state == ST_IDLE) |=>
      (cyc == (($past(instr.faddr) == PC_LOW_ADDR) ? 2'h2 : 2'h1)))
      else $error("cycle budget wrong");

   // Ordinary table read: busy for one more instruction cycle
   a_tread_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (instr_valid && q4 && instr.tread && state == ST_IDLE && instr.faddr != PC_LOW_ADDR) |=>
      busy [*4] ##1 !busy)
      else $error("table read not two cycles");

   // Table read into the counter low byte: two more cycles
   a_tread_pc_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (instr_valid && q4 && instr.tread && state == ST_IDLE && instr.faddr == PC_LOW_ADDR) |=>
      busy [*8] ##1 !busy)
      else $error("table read to counter low not three cycles");

   // Extra cycle ends on its own Q4
   a_extra_end: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (state == ST_EXTRA && q4) |=> (state == ST_IDLE && !busy))
      else $error("extra cycle not ended");

   // Busy is high exactly while a table read is in flight
   a_busy_state: assert property (@(posedge clk_sys) disable iff (!reset_n)
      busy == (state != ST_IDLE))
      else $error("busy out of step with state");

   // Swap is single cycle and leaves pointer and latch alone
   a_swap_single: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (instr_valid && q4 && instr.swap && state == ST_IDLE) |=>
      (!busy && state == ST_IDLE && $stable(table_pointer) && $stable(table_latch)))
      else $error("swap not single cycle");

   // No status flag write, ever
   a_no_status: assert property (@(posedge clk_sys) disable iff (!reset_n) !status_we)
      else $error("status flags written");

   // Main scenarios to be reached
   c_swap_work: cover property (@(posedge clk_sys) disable iff (!reset_n) wr.work_reg_we);
   c_swap_file: cover property (@(posedge clk_sys) disable iff (!reset_n) wr.file_we && !busy);
   c_tread_incr: cover property (@(posedge clk_sys) disable iff (!reset_n)
      state == ST_FETCH && q4 && incr_pend);
   c_tread_high: cover property (@(posedge clk_sys) disable iff (!reset_n)
      instr_valid && q4 && instr.tread && instr.byte_high && state == ST_IDLE);
   c_tread_pc_low: cover property (@(posedge clk_sys) disable iff (!reset_n) state == ST_EXTRA);
endmodule : nst_exec

// file: src/nst_pkg.sv
// Package for the nibble-swap and table-read execution block
// Summary of operation
// - Swap file nibbles; d selects destination
// - Table read first moves latch byte out
// - Byte select 1 high, 0 low
// - Then load latch from program memory
// - Increment bit advances pointer after load
// - Table read two cycles, three for counter low
package nst_pkg;
   localparam int DATA_W = 8;
   localparam int WORD_W = 16;
   localparam int NIB_LO = 0;
   localparam int NIB_HI = 4;
   localparam logic [7:0] PC_LOW_ADDR = 8'h02; // File address of program counter low
   localparam int TR_CYCLES = 2;
   localparam int TR_CYCLES_PC_LOW = 3;
   localparam logic [1:0] Q_LAST = 2'h3; // Q4 phase index
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [15:0] LATCH_RESET = 16'h0000;

   // Decoded instruction as handed over by the core decoder
   typedef struct packed {
      logic swap;      // nibble_swap_op
      logic tread;     // table_read_op
      logic dest_file; // swap: 1 writes file, 0 working register
      logic byte_high; // table read: 1 high byte, 0 low byte
      logic incr;      // table read: advance pointer
      logic [7:0] faddr;
   } nst_instr_t;

   // File write request toward data file or working register
   typedef struct packed {
      logic file_we;
      logic work_reg_we;
      logic [7:0] addr;
      logic [7:0] data;
   } nst_wr_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_EXTRA = 2'b10
   } nst_state_t;
endpackage : nst_pkg

// file: verification/nst_core_model.sv
// Core side model: phase sequencer and program memory
`timescale 1ns/1ps
module nst_core_model
   import nst_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [15:0] table_pointer,
   output logic [1:0] q_phase,
   output logic [15:0] pmem_rdata
);
   // Phase advances one per clock, Q1 after reset
   always_ff @(posedge clk_sys) begin
      q_phase <= reset_n ? q_phase + 2'h1 : 2'h0;
   end
   // Word pattern differs from its address
   assign pmem_rdata = table_pointer ^ 16'h5AC3;
endmodule : nst_core_model

// file: verification/nibble_swap_table_read_exec_tb_top.sv
// Bench for nibble swap and table read execution
`timescale 1ns/1ps
module nibble_swap_table_read_exec_tb_top;
   import nst_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic instr_valid = 1'b0;
   nst_instr_t instr = '0;
   logic [7:0] file_rdata = 8'h00;
   logic [1:0] q_phase;
   logic [15:0] pmem_rdata, table_pointer, table_latch;
   logic [15:0] exp_ptr = PTR_RESET;
   logic [15:0] exp_lat = LATCH_RESET;
   nst_wr_t wr;
   logic busy, status_we;
   int err_count = 0;
   int cmp_count = 0;
   nst_exec u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .q_phase(q_phase), .instr_valid(instr_valid),
      .instr(instr), .file_rdata(file_rdata), .pmem_rdata(pmem_rdata), .wr(wr),
      .table_pointer(table_pointer), .table_latch(table_latch), .busy(busy), .status_we(status_we));
   nst_core_model u_core (.clk_sys(clk_sys), .reset_n(reset_n), .table_pointer(table_pointer),
      .q_phase(q_phase), .pmem_rdata(pmem_rdata));
   // Clock of 8 ns
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic give_verdict;
      if (err_count == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   task automatic chk_wr(input nst_wr_t exp);
      cmp_count++;
      if (wr !== exp || status_we !== 1'b0) begin
         err_count++;
         $display("Error %0t: write %h expected %h", $time, wr, exp);
      end
   endtask : chk_wr
   task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: word %h expected %h", $time, got, exp);
      end
   endtask : chk_w
   // Present one instruction at the next Q4
   task automatic issue(input nst_instr_t i, input logic [7:0] fd);
      int n;
      for (n = 0; n < 8 && q_phase !== Q_LAST; n++) @(posedge clk_sys) #1;
      if (n == 8) begin
         err_count++;
         give_verdict();
      end
      instr = i;
      file_rdata = fd;
      instr_valid = 1'b1;
      @(posedge clk_sys) #1;
      instr_valid = 1'b0;
   endtask : issue
   task automatic swap(input logic [7:0] v, input logic d);
      issue('{swap:1'b1, tread:1'b0, dest_file:d, byte_high:1'b0, incr:1'b0, faddr:8'h20}, v);
      chk_wr('{file_we:d, work_reg_we:!d, addr:8'h20, data:{v[3:0], v[7:4]}});
   endtask : swap
   task automatic tread(input logic hi, input logic inc, input logic [7:0] fa, input int cyc);
      int n;
      issue('{swap:1'b0, tread:1'b1, dest_file:1'b0, byte_high:hi, incr:inc, faddr:fa}, 8'hFF);
      chk_wr('{file_we:1'b1, work_reg_we:1'b0, addr:fa, data:hi ? exp_lat[15:8] : exp_lat[7:0]});
      for (n = 0; n < 12 && busy === 1'b1; n++) @(posedge clk_sys) #1;
      chk_w(16'(n), 16'(4 * cyc - 4));
      if (n == 12) begin
         err_count++;
         give_verdict();
      end
      exp_lat = exp_ptr ^ 16'h5AC3;
      exp_ptr = exp_ptr + 16'(inc);
      chk_w(table_latch, exp_lat);
      chk_w(table_pointer, exp_ptr);
   endtask : tread
   // Reset in mid-run clears pointer, latch, busy and write
   task automatic reset_mid;
      reset_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      exp_ptr = PTR_RESET;
      exp_lat = LATCH_RESET;
      chk_w(table_pointer, exp_ptr);
      chk_w(table_latch, exp_lat);
      chk_w(16'(busy), 16'h0000);
      chk_wr('0);
   endtask : reset_mid
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      chk_w(table_latch, LATCH_RESET);
      swap(8'h53, 1'b0);
      swap(8'hA0, 1'b1);
      tread(1'b0, 1'b1, 8'h10, TR_CYCLES);
      tread(1'b1, 1'b0, 8'h11, TR_CYCLES);
      tread(1'b1, 1'b1, PC_LOW_ADDR, TR_CYCLES_PC_LOW);
      tread(1'b0, 1'b0, 8'h12, TR_CYCLES);
      reset_mid();
      tread(1'b0, 1'b1, 8'h13, TR_CYCLES);
      swap(8'h0F, 1'b1);
      give_verdict();
   end
endmodule : nibble_swap_table_read_exec_tb_top
